// ==== shared/zoi_pkg.sv ====
package zoi_pkg;
   // register bus geometry
   localparam int DATA_W = 16;
   localparam int ADDR_W = 8;
   localparam int MAG_W = 16;
   localparam int DLY_W = 14;
   localparam int ELEM_N = 6;

   // register word indices
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_PICK_BASE = 8'h01;
   localparam logic [7:0] OFS_DELAY_BASE = 8'h07;
   localparam logic [7:0] OFS_TOC_PHASE = 8'h0d;
   localparam logic [7:0] OFS_TOC_GROUND = 8'h0e;
   localparam logic [7:0] OFS_STATUS = 8'h0f;
   localparam logic [7:0] OFS_IRQ_EN = 8'h10;
   localparam logic [7:0] OFS_IRQ_CLR = 8'h11;
   localparam logic [7:0] OFS_LIVE = 8'h12;

   // control field positions and reset value
   localparam int CTRL_GND_EN_BIT = 0;
   localparam int CTRL_ZOUT_LSB = 1;
   localparam int CTRL_ZIN_LSB = 3;
   localparam logic [15:0] CTRL_RESET = 16'h0001;
   localparam logic [15:0] SETTING_RESET = 16'h0000;

   // status / interrupt bit positions
   localparam int EV_TRIP = 0;
   localparam int EV_ZOUT_ON = 1;
   localparam int EV_ZONE_TRIP = 2;
   localparam int EV_BF_REMOVE = 3;
   localparam int EV_TIMEOUT_REMOVE = 4;
   localparam int EV_N = 5;

   // power-cycle counts
   localparam logic [3:0] QUAL_CYCLES = 4'h3;
   localparam logic [3:0] REMOVE_CYCLES = 4'ha;

   typedef enum logic [1:0] {
      ZOUT_OFF = 2'b00,
      ZOUT_PHASE = 2'b01,
      ZOUT_GROUND = 2'b10,
      ZOUT_BOTH = 2'b11
   } zoi_zout_t;

   typedef enum logic [1:0] {
      ZIN_OFF = 2'b00,
      ZIN_PHASE = 2'b01,
      ZIN_GROUND = 2'b10,
      ZIN_RSVD = 2'b11
   } zoi_zin_t;

   typedef enum logic [1:0] {
      ZO_IDLE = 2'b00,
      ZO_DRIVE = 2'b01,
      ZO_HELD = 2'b10
   } zoi_zo_state_t;
endpackage

// ==== shared/zoi_elem_if.sv ====
`timescale 1ns/1ns
interface zoi_elem_if #(parameter int MAG_W = 16, parameter int DLY_W = 14);
   logic [MAG_W-1:0] magnitude;
   logic [MAG_W-1:0] level;
   logic [DLY_W-1:0] delay;
   logic pickup;
   logic trip;
   modport ctl (output magnitude, output level, output delay, input pickup, input trip);
   modport elem (input magnitude, input level, input delay, output pickup, output trip);
endinterface

// ==== src/zoi_oc_element.sv ====
`timescale 1ns/1ns
module zoi_oc_element #(parameter int DLY_W = 14)
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // power-cycle timebase
   input wire logic cycle_tick,
   // settings, measurement and result
   zoi_elem_if.elem elem
);
   logic [DLY_W-1:0] count;
   logic [DLY_W-1:0] next_count;

   // a zero level means the element is switched off
   assign elem.pickup = (elem.level != '0) && (elem.magnitude > elem.level);
   // zero delay gives an instantaneous element
   assign elem.trip = elem.pickup && (count >= elem.delay);

   // delay counter restarts whenever the pickup drops
   always_comb
   begin
      next_count = count;
      if (!elem.pickup)
         next_count = '0;
      else if (cycle_tick && (count < elem.delay))
         next_count = DLY_W'(count + 1'b1);
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         count <= '0;
      else
         count <= next_count;
   end
endmodule

// ==== src/zoi_cycle_timer.sv ====
`timescale 1ns/1ns
module zoi_cycle_timer #(parameter int CW = 4)
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // timing control
   input wire logic cycle_tick,
   input wire logic run,
   input wire logic [CW-1:0] limit,
   // result
   output logic done
);
   logic [CW-1:0] count;
   logic [CW-1:0] next_count;

   assign done = run && (count >= limit);

   // counts power cycles while run holds, saturating at the limit
   always_comb
   begin
      next_count = count;
      if (!run)
         next_count = '0;
      else if (cycle_tick && (count < limit))
         next_count = CW'(count + 1'b1);
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         count <= '0;
      else
         count <= next_count;
   end
endmodule

// ==== src/zoi_trip_core.sv ====
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ns
module zoi_trip_core #(
   parameter int MAG_W = zoi_pkg::MAG_W,
   parameter int DLY_W = zoi_pkg::DLY_W
)
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // register port
   input wire logic [zoi_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [zoi_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [zoi_pkg::DATA_W-1:0] reg_rdata,
   // measurement front end
   input wire logic cycle_tick,
   input wire logic [MAG_W-1:0] phase_magnitude,
   input wire logic [MAG_W-1:0] ground_magnitude,
   input wire logic [MAG_W-1:0] residual_magnitude,
   input wire logic curve_trip_phase,
   input wire logic curve_trip_ground,
   // zone interlock pair and breaker supervision
   input wire logic zone_in,
   output logic zone_out,
   input wire logic breaker_fail,
   // results
   output logic trip,
   output logic irq
);
   localparam int DW = zoi_pkg::DATA_W;
   localparam int EN = zoi_pkg::ELEM_N;

   // settings wider than the register word cannot be loaded
   if (MAG_W > DW || DLY_W > DW || MAG_W < 4 || DLY_W < 4)
   begin : g_bad_width
      $error("zoi_trip_core: MAG_W and DLY_W must lie between 4 and the data width");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // register file

   logic [DW-1:0] ctrl, next_ctrl;
   logic [MAG_W-1:0] pick_set [EN];
   logic [MAG_W-1:0] next_pick_set [EN];
   logic [DLY_W-1:0] dly_set [EN];
   logic [DLY_W-1:0] next_dly_set [EN];
   logic [MAG_W-1:0] toc_phase, next_toc_phase;
   logic [MAG_W-1:0] toc_ground, next_toc_ground;
   logic [zoi_pkg::EV_N-1:0] status, next_status;
   logic [zoi_pkg::EV_N-1:0] irq_en, next_irq_en;
   logic [zoi_pkg::EV_N-1:0] events;
   logic [DW-1:0] next_rdata;

   // decoded settings
   logic gnd_en;
   zoi_pkg::zoi_zout_t zout_sel;
   zoi_pkg::zoi_zin_t zin_sel;
   assign gnd_en = ctrl[zoi_pkg::CTRL_GND_EN_BIT];
   assign zout_sel = zoi_pkg::zoi_zout_t'(ctrl[zoi_pkg::CTRL_ZOUT_LSB +: 2]);
   assign zin_sel = zoi_pkg::zoi_zin_t'(ctrl[zoi_pkg::CTRL_ZIN_LSB +: 2]);

   // live state read back by software
   logic phase_pick_any, ground_pick_any, any_pick;
   logic zone_qual, zone_done, remove_done, operated;
   zoi_pkg::zoi_zo_state_t zo_state, next_zo_state;

   // register writes; all six elements share one setting format so any may be
   // used as instantaneous or short delay
   always_comb
   begin
      next_ctrl = ctrl;
      next_pick_set = pick_set;
      next_dly_set = dly_set;
      next_toc_phase = toc_phase;
      next_toc_ground = toc_ground;
      next_irq_en = irq_en;
      if (reg_write)
      begin
         if (reg_addr == zoi_pkg::OFS_CTRL)
            next_ctrl = reg_wdata;
         if (reg_addr == zoi_pkg::OFS_TOC_PHASE)
            next_toc_phase = reg_wdata[MAG_W-1:0];
         if (reg_addr == zoi_pkg::OFS_TOC_GROUND)
            next_toc_ground = reg_wdata[MAG_W-1:0];
         if (reg_addr == zoi_pkg::OFS_IRQ_EN)
            next_irq_en = reg_wdata[zoi_pkg::EV_N-1:0];
         for (int i = 0; i < EN; i++)
         begin
            if (reg_addr == zoi_pkg::OFS_PICK_BASE + 8'(i))
               next_pick_set[i] = reg_wdata[MAG_W-1:0];
            if (reg_addr == zoi_pkg::OFS_DELAY_BASE + 8'(i))
               next_dly_set[i] = reg_wdata[DLY_W-1:0];
         end
      end
   end

   // sticky status: a new event wins over a clear in the same cycle
   always_comb
   begin
      next_status = status;
      if (reg_write && reg_addr == zoi_pkg::OFS_IRQ_CLR)
         next_status = status & ~reg_wdata[zoi_pkg::EV_N-1:0];
      next_status = next_status | events;
   end

   // read data appear in the following cycle only; unmapped words read zero
   always_comb
   begin
      next_rdata = '0;
      if (reg_read)
      begin
         unique case (reg_addr)
            zoi_pkg::OFS_CTRL: next_rdata = ctrl;
            zoi_pkg::OFS_TOC_PHASE: next_rdata = DW'(toc_phase);
            zoi_pkg::OFS_TOC_GROUND: next_rdata = DW'(toc_ground);
            zoi_pkg::OFS_STATUS: next_rdata = DW'(status);
            zoi_pkg::OFS_IRQ_EN: next_rdata = DW'(irq_en);
            zoi_pkg::OFS_LIVE: next_rdata = DW'({operated, zone_qual, zone_out, trip,
                                                 ground_pick_any, phase_pick_any});
            default:
            begin
               for (int i = 0; i < EN; i++)
               begin
                  if (reg_addr == zoi_pkg::OFS_PICK_BASE + 8'(i))
                     next_rdata = DW'(pick_set[i]);
                  if (reg_addr == zoi_pkg::OFS_DELAY_BASE + 8'(i))
                     next_rdata = DW'(dly_set[i]);
               end
            end
         endcase
      end
   end

   // zone fields reset to disabled so a fresh relay never interlocks
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         ctrl <= zoi_pkg::CTRL_RESET;
         for (int i = 0; i < EN; i++)
         begin
            pick_set[i] <= MAG_W'(zoi_pkg::SETTING_RESET);
            dly_set[i] <= DLY_W'(zoi_pkg::SETTING_RESET);
         end
         toc_phase <= MAG_W'(zoi_pkg::SETTING_RESET);
         toc_ground <= MAG_W'(zoi_pkg::SETTING_RESET);
         status <= '0;
         irq_en <= '0;
         reg_rdata <= '0;
      end
      else
      begin
         ctrl <= next_ctrl;
         pick_set <= next_pick_set;
         dly_set <= next_dly_set;
         toc_phase <= next_toc_phase;
         toc_ground <= next_toc_ground;
         status <= next_status;
         irq_en <= next_irq_en;
         reg_rdata <= next_rdata;
      end
   end

   assign irq = |(status & irq_en);

   ////////////////////////////////////////////////////////////////////////////////
   // overcurrent elements: 0,1 phase; 2,3 measured ground; 4,5 residual

   logic [EN-1:0] elem_pick;
   logic [EN-1:0] elem_trip;

   for (genvar g = 0; g < EN; g++)
   begin : g_elem
      zoi_elem_if #(.MAG_W(MAG_W), .DLY_W(DLY_W)) link ();
      // ground elements see a zero level, i.e. off, while ground protection is disabled
      assign link.level = (g >= 2 && !gnd_en) ? '0 : pick_set[g];
      assign link.magnitude = (g < 2) ? phase_magnitude :
                              (g < 4) ? ground_magnitude : residual_magnitude;
      assign link.delay = dly_set[g];
      assign elem_pick[g] = link.pickup;
      assign elem_trip[g] = link.trip;
      zoi_oc_element #(.DLY_W(DLY_W)) u_elem (
         .clk(clk),
         .reset(reset),
         .cycle_tick(cycle_tick),
         .elem(link.elem)
      );
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pickup summaries

   logic phase_toc_pick, ground_toc_pick, phase_toc_scaled;
   logic [MAG_W+1:0] phase_x2, toc_x3;

   // curve pickups; the ground curve covers measured and residual current
   assign phase_toc_pick = (toc_phase != '0) && (phase_magnitude > toc_phase);
   assign ground_toc_pick = gnd_en && (toc_ground != '0) &&
                            (ground_magnitude > toc_ground || residual_magnitude > toc_ground);
   assign phase_pick_any = |elem_pick[1:0] || phase_toc_pick;
   assign ground_pick_any = |elem_pick[5:2] || ground_toc_pick;
   assign any_pick = phase_pick_any || ground_pick_any;

   // 2*I > 3*pickup avoids a divider; keeps light overloads off the fast path
   assign phase_x2 = {1'b0, phase_magnitude, 1'b0};
   assign toc_x3 = {2'b00, toc_phase} + {1'b0, toc_phase, 1'b0};
   assign phase_toc_scaled = (toc_phase != '0) && (phase_x2 > toc_x3);

   ////////////////////////////////////////////////////////////////////////////////
   // zone-in qualification and three-cycle fast trip

   always_comb
   begin
      unique case (zin_sel)
         zoi_pkg::ZIN_PHASE: zone_qual = |elem_pick[1:0] || phase_toc_scaled;
         zoi_pkg::ZIN_GROUND: zone_qual = ground_pick_any;
         default: zone_qual = 1'b0;
      endcase
   end

   // downstream relays signal by driving zone_in; then only element delays and the curve trips apply
   zoi_cycle_timer #(.CW(4)) u_qual (
      .clk(clk),
      .reset(reset),
      .cycle_tick(cycle_tick),
      .run(zone_qual && !zone_in),
      .limit(zoi_pkg::QUAL_CYCLES),
      .done(zone_done)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // trip decision: every criterion ORed, no arbitration

   logic next_trip, next_operated;

   always_comb
   begin
      next_trip = |elem_trip || curve_trip_phase || (gnd_en && curve_trip_ground) ||
                  zone_done;
      next_operated = trip || (operated && any_pick);
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         trip <= 1'b0;
         operated <= 1'b0;
      end
      else
      begin
         trip <= next_trip;
         operated <= next_operated;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // zone-out drive

   logic zout_want;

   always_comb
   begin
      unique case (zout_sel)
         zoi_pkg::ZOUT_PHASE: zout_want = phase_pick_any;
         zoi_pkg::ZOUT_GROUND: zout_want = ground_pick_any;
         zoi_pkg::ZOUT_BOTH: zout_want = any_pick;
         zoi_pkg::ZOUT_OFF: zout_want = 1'b0;
      endcase
   end

   // operated with current still present: give up blocking after ten cycles
   zoi_cycle_timer #(.CW(4)) u_remove (
      .clk(clk),
      .reset(reset),
      .cycle_tick(cycle_tick),
      .run(operated && any_pick && zo_state == zoi_pkg::ZO_DRIVE),
      .limit(zoi_pkg::REMOVE_CYCLES),
      .done(remove_done)
   );

   // held stays off until the fault clears so a stuck breaker cannot re-block upstream
   always_comb
   begin
      next_zo_state = zo_state;
      unique case (zo_state)
         zoi_pkg::ZO_IDLE:
            if (zout_want && !breaker_fail)
               next_zo_state = zoi_pkg::ZO_DRIVE;
         zoi_pkg::ZO_DRIVE:
            if (breaker_fail || remove_done)
               next_zo_state = zoi_pkg::ZO_HELD;
            else if (!zout_want)
               next_zo_state = zoi_pkg::ZO_IDLE;
         zoi_pkg::ZO_HELD:
            if (!zout_want)
               next_zo_state = zoi_pkg::ZO_IDLE;
         default:
            next_zo_state = zoi_pkg::ZO_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         zo_state <= zoi_pkg::ZO_IDLE;
      else
         zo_state <= next_zo_state;
   end

   // breaker failure gates the pin directly, no clock of latency
   assign zone_out = (zo_state == zoi_pkg::ZO_DRIVE) && !breaker_fail;

   // interrupt sources
   always_comb
   begin
      events = '0;
      events[zoi_pkg::EV_TRIP] = next_trip && !trip;
      events[zoi_pkg::EV_ZONE_TRIP] = next_trip && !trip && zone_done;
      events[zoi_pkg::EV_ZOUT_ON] = zo_state == zoi_pkg::ZO_IDLE &&
                                    next_zo_state == zoi_pkg::ZO_DRIVE;
      events[zoi_pkg::EV_BF_REMOVE] = zo_state == zoi_pkg::ZO_DRIVE && breaker_fail;
      events[zoi_pkg::EV_TIMEOUT_REMOVE] = zo_state == zoi_pkg::ZO_DRIVE &&
                                           !breaker_fail && remove_done;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_done_rise;
      $rose(zone_done);
   endsequence
   sequence s_qual_open;
      zone_qual && !zone_in && zin_sel != zoi_pkg::ZIN_OFF;
   endsequence

   property p_zout_disabled;
      zout_sel == zoi_pkg::ZOUT_OFF |=> !zone_out;
   endproperty
   a_zout_disabled: assert property (p_zout_disabled) else $error("zone-out while disabled");

   property p_bf_removes;
      breaker_fail |-> !zone_out;
   endproperty
   a_bf_removes: assert property (p_bf_removes) else $error("zone-out during breaker fail");

   property p_phase_only;
      zout_sel == zoi_pkg::ZOUT_PHASE && !phase_pick_any |=> !zone_out;
   endproperty
   a_phase_only: assert property (p_phase_only) else $error("zone-out without phase pickup");

   property p_ground_only;
      zout_sel == zoi_pkg::ZOUT_GROUND && !ground_pick_any |=> !zone_out;
   endproperty
   a_ground_only: assert property (p_ground_only) else $error("zone-out without ground pickup");

   property p_both_drives;
      zout_sel == zoi_pkg::ZOUT_BOTH && any_pick && zo_state == zoi_pkg::ZO_IDLE
         && !breaker_fail ##1 !breaker_fail |-> zone_out;
   endproperty
   a_both_drives: assert property (p_both_drives) else $error("zone-out missing on pickup");

   property p_zone_trip;
      s_qual_open ##0 s_done_rise |=> trip;
   endproperty
   a_zone_trip: assert property (p_zone_trip) else $error("zone trip not taken");

   property p_zin_blocks;
      zone_in |-> !zone_done;
   endproperty
   a_zin_blocks: assert property (p_zin_blocks) else $error("fast trip with zone-in active");

   property p_gnd_disabled;
      !gnd_en |-> !ground_pick_any && !(|elem_pick[5:2]);
   endproperty
   a_gnd_disabled: assert property (p_gnd_disabled) else $error("ground pickup while disabled");

   property p_timeout_remove;
      $rose(remove_done) |=> !zone_out;
   endproperty
   a_timeout_remove: assert property (p_timeout_remove) else $error("zone-out kept after timeout");
endmodule

// ==== sim/zoi_downstream_relay.sv ====
`timescale 1ns/1ns
// downstream relay on the shared pair: drives it a few clocks after it sees a fault
module zoi_downstream_relay
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // fault seen downstream and reaction lag in clocks
   input wire logic fault_seen,
   input wire logic [3:0] lag,
   // shared pair, high while driven
   output logic zone_drive
);
   logic [3:0] wait_cnt;
   // pair is released as soon as the fault goes; nothing is held over
   always_ff @(posedge clk)
   begin
      if (reset || !fault_seen)
      begin
         wait_cnt <= 4'h0;
         zone_drive <= 1'b0;
      end
      else if (wait_cnt < lag)
         wait_cnt <= wait_cnt + 4'h1;
      else
         zone_drive <= 1'b1;
   end
endmodule

// ==== sim/zoi_trip_core_tb_top.sv ====
`timescale 1ns/1ns
module zoi_trip_core_tb_top;
   logic clk, reset, reg_write, reg_read, cycle_tick, curve_trip_phase, curve_trip_ground;
   logic zone_in, zone_out, breaker_fail, trip, irq, fault_seen, rd_due;
   logic [7:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, phase_magnitude, ground_magnitude, residual_magnitude;
   logic [15:0] hi, lo;
   logic [15:0] exp_q[$];
   logic [1:0] sel;
   integer failures, cmp_count, seed, s, src;

   zoi_trip_core u_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .cycle_tick(cycle_tick), .phase_magnitude(phase_magnitude),
      .ground_magnitude(ground_magnitude), .residual_magnitude(residual_magnitude),
      .curve_trip_phase(curve_trip_phase), .curve_trip_ground(curve_trip_ground),
      .zone_in(zone_in), .zone_out(zone_out), .breaker_fail(breaker_fail), .trip(trip),
      .irq(irq));
   zoi_downstream_relay u_down (.clk(clk), .reset(reset), .fault_seen(fault_seen),
      .lag(4'h3), .zone_drive(zone_in));

   ////////////////////////////////////////////////////////////////////////////////
   // 50 ns clock
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic cmp16(input string name, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e)
      begin
         failures++;
         $display("ERROR %s expected %h seen %h", name, e, g);
      end
   endtask

   task automatic cmp1(input string name, input logic e, input logic g);
      cmp_count++;
      if (g !== e)
      begin
         failures++;
         $display("ERROR %s expected %b seen %b", name, e, g);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // bus and stimulus tasks; every change lands by non-blocking assignment after an edge
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask

   // expected read data is queued before the strobe so the monitor always finds it
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      @(posedge clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_read <= 1'b0;
   endtask

   task automatic mags(input logic [15:0] p, input logic [15:0] g, input logic [15:0] r);
      @(posedge clk);
      phase_magnitude <= p;
      ground_magnitude <= g;
      residual_magnitude <= r;
   endtask

   task automatic ticks(input int n);
      repeat (n)
      begin
         @(posedge clk);
         cycle_tick <= 1'b1;
         @(posedge clk);
         cycle_tick <= 1'b0;
      end
   endtask

   // sample on the falling edge so the design's registers have settled
   task automatic look(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask

   task automatic restart;
      @(posedge clk);
      reset <= 1'b1;
      fault_seen <= 1'b0;
      breaker_fail <= 1'b0;
      curve_trip_phase <= 1'b0;
      curve_trip_ground <= 1'b0;
      mags(16'h0000, 16'h0000, 16'h0000);
      @(posedge clk);
      reset <= 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // read data stands only in the cycle after the strobe
   always @(posedge clk) rd_due <= reg_read;
   always @(negedge clk)
      if (rd_due)
         cmp16("reg_rdata", exp_q.pop_front(), reg_rdata);

   // watchdog, far beyond the few hundred clocks the sequence needs
   initial
   begin
      repeat (20000) @(posedge clk);
      failures++;
      $display("ERROR watchdog expected done seen hang");
      print_verdict;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      {reset, reg_write, reg_read, cycle_tick, curve_trip_phase, curve_trip_ground} = 6'h20;
      {breaker_fail, fault_seen} = 2'h0;
      {reg_addr, reg_wdata, phase_magnitude, ground_magnitude, residual_magnitude} = '0;
      {failures, cmp_count} = 0;
      seed = 75173;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      look(1);
      cmp1("zone_out", 1'b0, zone_out);
      rd(zoi_pkg::OFS_CTRL, zoi_pkg::CTRL_RESET);
      rd(8'h20, 16'h0000);
      rd(zoi_pkg::OFS_IRQ_CLR, 16'h0000);
      // first element of each pair, delay 0, under every zone-out selection
      wr(8'h01, 16'h0064);
      wr(8'h03, 16'h0064);
      wr(8'h05, 16'h0064);
      for (s = 0; s < 4; s++)
         for (src = 0; src < 3; src++)
         begin
            sel = s[1:0];
            wr(zoi_pkg::OFS_CTRL, 16'h0001 | (16'(s) << 1));
            hi = 16'h0065 + 16'($random(seed) & 32'h3ff);
            lo = 16'($random(seed) & 32'h3f);
            mags(src == 0 ? hi : lo, src == 1 ? hi : lo, src == 2 ? hi : lo);
            look(2);
            cmp1("zone_out", src == 0 ? sel[0] : sel[1], zone_out);
            cmp1("trip", 1'b1, trip);
            mags(lo, lo, lo);
            look(2);
            cmp1("zone_out", 1'b0, zone_out);
         end
      // ground disabled, then enabled, on the second measured ground element and curve
      restart;
      wr(zoi_pkg::OFS_CTRL, 16'h0004);
      wr(8'h04, 16'h0064);
      mags(16'h0000, 16'h00c8, 16'h0000);
      curve_trip_ground <= 1'b1;
      look(3);
      cmp1("zone_out", 1'b0, zone_out);
      cmp1("trip", 1'b0, trip);
      wr(zoi_pkg::OFS_CTRL, 16'h0005);
      look(2);
      cmp1("zone_out", 1'b1, zone_out);
      cmp1("trip", 1'b1, trip);
      mags(16'h0000, 16'h0000, 16'h0000);
      look(2);
      cmp1("trip", 1'b1, trip);
      // zone trip after three ticks, interrupt, then the ten-tick removal
      restart;
      wr(zoi_pkg::OFS_CTRL, 16'h000b);
      wr(8'h01, 16'h0064);
      wr(zoi_pkg::OFS_DELAY_BASE, 16'h0005);
      wr(zoi_pkg::OFS_IRQ_EN, 16'h0001);
      mags(16'h00c8, 16'h0000, 16'h0000);
      ticks(2);
      look(2);
      cmp1("trip", 1'b0, trip);
      cmp1("irq", 1'b0, irq);
      ticks(1);
      look(2);
      cmp1("trip", 1'b1, trip);
      cmp1("irq", 1'b1, irq);
      rd(zoi_pkg::OFS_STATUS, 16'h0007);
      wr(zoi_pkg::OFS_IRQ_CLR, 16'h001f);
      look(1);
      cmp1("irq", 1'b0, irq);
      rd(zoi_pkg::OFS_STATUS, 16'h0000);
      ticks(9);
      look(1);
      cmp1("zone_out", 1'b1, zone_out);
      ticks(1);
      look(2);
      cmp1("zone_out", 1'b0, zone_out);
      rd(zoi_pkg::OFS_STATUS, 16'h0010);
      // downstream relay holds the pair: only the element delay of five ticks applies
      restart;
      wr(zoi_pkg::OFS_CTRL, 16'h000b);
      wr(8'h01, 16'h0064);
      wr(zoi_pkg::OFS_DELAY_BASE, 16'h0005);
      fault_seen <= 1'b1;
      look(6);
      mags(16'h00c8, 16'h0000, 16'h0000);
      ticks(4);
      look(2);
      cmp1("trip", 1'b0, trip);
      ticks(1);
      look(2);
      cmp1("trip", 1'b1, trip);
      // phase zone-in needs strictly more than 1.5 times the curve pickup
      restart;
      wr(zoi_pkg::OFS_CTRL, 16'h000b);
      wr(zoi_pkg::OFS_TOC_PHASE, 16'h0064);
      mags(16'h0096, 16'h0000, 16'h0000);
      ticks(3);
      look(2);
      cmp1("trip", 1'b0, trip);
      cmp1("zone_out", 1'b1, zone_out);
      // the outside curve trip is one more criterion in parallel with the elements
      @(posedge clk);
      curve_trip_phase <= 1'b1;
      look(2);
      cmp1("trip", 1'b1, trip);
      @(posedge clk);
      curve_trip_phase <= 1'b0;
      look(2);
      cmp1("trip", 1'b0, trip);
      mags(16'h0097, 16'h0000, 16'h0000);
      ticks(3);
      look(2);
      cmp1("trip", 1'b1, trip);
      // ground zone-in ignores phase, takes residual over the unscaled curve pickup
      restart;
      wr(zoi_pkg::OFS_CTRL, 16'h0011);
      wr(zoi_pkg::OFS_TOC_PHASE, 16'h0064);
      wr(zoi_pkg::OFS_TOC_GROUND, 16'h0064);
      mags(16'h03e8, 16'h0000, 16'h0000);
      ticks(3);
      look(2);
      cmp1("trip", 1'b0, trip);
      mags(16'h0000, 16'h0000, 16'h0065);
      ticks(3);
      look(2);
      cmp1("trip", 1'b1, trip);
      // breaker failure drops zone-out in the same cycle and keeps it down
      restart;
      wr(zoi_pkg::OFS_CTRL, 16'h0003);
      wr(8'h01, 16'h0064);
      mags(16'h00c8, 16'h0000, 16'h0000);
      look(2);
      cmp1("zone_out", 1'b1, zone_out);
      @(posedge clk);
      breaker_fail <= 1'b1;
      @(negedge clk);
      cmp1("zone_out", 1'b0, zone_out);
      @(posedge clk);
      breaker_fail <= 1'b0;
      look(2);
      cmp1("zone_out", 1'b0, zone_out);
      rd(zoi_pkg::OFS_STATUS, 16'h000b);
      rd(zoi_pkg::OFS_LIVE, 16'h0025);
      rd(zoi_pkg::OFS_PICK_BASE, 16'h0064);
      look(2);
      print_verdict;
   end
endmodule
